/* ddcr_consts.svh */
// Register offsets, field positions, reset values and counts of the capture retimer
`ifndef DDCR_CONSTS_SVH
`define DDCR_CONSTS_SVH

// Register offsets (register port address)
`define DDCR_ADDR_REF      5'h01
`define DDCR_ADDR_DATA     5'h02
`define DDCR_ADDR_PHASE    5'h14

// Reference control register fields
`define DDCR_BIT_REF_DIS   0

// Data interface control register fields
`define DDCR_BIT_DBL       0
`define DDCR_BIT_SGL       1
`define DDCR_BIT_IE        2
`define DDCR_BIT_RISING    4
`define DDCR_BIT_FIRST     5
`define DDCR_BIT_TWOS      7

// Retimer phase control and status fields
`define DDCR_BIT_IPH       0
`define DDCR_BIT_OVR       2
`define DDCR_BIT_REACQ     3
`define DDCR_BIT_SEARCH    4
`define DDCR_BIT_QPH       6
`define DDCR_PHASE_WMASK   8'hCF

// Reset values
`define DDCR_RST_REF       8'h00
`define DDCR_RST_DATA      8'h04
`define DDCR_RST_PHASE     8'h00

// Sample width, FIFO depth, search bound in conversion cycles, fixed phase code
`define DDCR_DW            14
`define DDCR_FIFO_DEPTH    16
`define DDCR_SEARCH_LAST   8'h7F
`define DDCR_FIXED_CODE    2'h0

`endif

/* ddcr_fpga_model.sv */
// FPGA-side model: in-phase qualifier clock and interleaved tagged words
`timescale 1ns/1ps
module ddcr_fpga_model (
   input  wire logic        i_clk,
   input  wire logic        i_conv,
   input  wire logic        i_hold,
   output logic             o_qclk,
   output logic [13:0]      o_bus
);
   logic [2:0]  cnt = 3'h0;
   logic        last = 1'b0;
   logic [12:0] seq = 13'h0000;

   // Qualifier tied in phase to conversion clock; held low when parked
   assign o_qclk = i_conv & ~i_hold;

   // Word changes mid half-period so it is settled across both edges
   always @(negedge i_clk) begin
      cnt <= (i_conv != last) ? 3'h0 : cnt + 3'h1;
      last <= i_conv;
      if (cnt == 3'h1 && !i_conv) begin
         seq <= seq + 13'h0001;
         o_bus <= {1'b0, seq + 13'h0001}; // Tag 0 marks the rising-edge word
      end else if (cnt == 3'h1) begin
         o_bus <= {1'b1, seq}; // Same count, falling-edge word
      end
   end
endmodule

/* ddcr_pkg.sv */
// Types and shared functions of the capture retimer
package ddcr_pkg;

   // Phase search states, one-hot
   typedef enum logic [2:0] {
      DDCR_LOCKED  = 3'h1,
      DDCR_WAIT    = 3'h2,
      DDCR_MEASURE = 3'h4
   } ddcr_srch_t;

   // Retimer phase number for a two-bit phase code
   function automatic logic [1:0] ddcr_phase_of(input logic [1:0] code);
      unique case (code)
         2'h0: ddcr_phase_of = 2'h2;
         2'h1: ddcr_phase_of = 2'h3;
         2'h2: ddcr_phase_of = 2'h3;
         2'h3: ddcr_phase_of = 2'h1;
      endcase
   endfunction

   // Quarter of the conversion period in which the qualifier edge fell
   function automatic logic [1:0] ddcr_quadrant(input logic [7:0] d, input logic [7:0] p);
      logic [9:0] d4;
      logic [9:0] p1;
      logic [9:0] p2;
      logic [9:0] p3;
      d4 = {d, 2'h0};
      p1 = {2'h0, p};
      p2 = {1'h0, p, 1'h0};
      p3 = p1 + p2;
      if (d4 < p1) ddcr_quadrant = 2'h0;
      else if (d4 < p2) ddcr_quadrant = 2'h1;
      else if (d4 < p3) ddcr_quadrant = 2'h2;
      else ddcr_quadrant = 2'h3;
   endfunction

endpackage

/* ddcr_top.sv */
// Sample capture, retiming FIFO and register file of the dual converter input
`timescale 1ns/1ps
`include "ddcr_consts.svh"

// Behaviour
// - I and Q words share one DDR bus qualified by the data clock
// - Sample words are read as unsigned binary or twos complement per format bit
// - Data control bit 4 picks the rising or falling edge for the I word
// - Data control bit 5 picks whether I or Q is latched first per period
// - Captured pairs pass the retimer before loading the converter core register
// - With data control bit 2 clear, the conversion clock captures data
// - Clock-out bits 1 or 0 drive a qualifier clock made from conversion clock
// - Retimer compares both clocks and selects one of three transfer phases
// - Any working phase may be chosen; the safest is not sought
// - Code 00 is phase 2, 01 and 10 phase 3, 11 phase 1
// - After reset the retimer locks within 128 cycles, then clears searching
// - Searching stays high until the clock relationship is established or the 128-cycle search bound is reached
// - A zero-to-one write of the reacquire bit restarts both phase searches
// - I and Q phase fields read back chosen phases, valid once searching clears
// - With override set, the written I phase field forces both retimers
// - Pin mode with serial clock pin low uses fixed phase 2
// - Pin mode with serial clock pin high searches; each rise re-evaluates
// - Latency depends on phase; phase 2 gives I four, Q three and half cycles
// - Reference bit 0 set disables the internal reference; clear uses it

// Word FIFO between the capture side and the retimer
module ddcr_fifo #(
   parameter int W = 28,
   parameter int D = 16
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_out_valid,
   input  wire logic         i_out_ready,
   output logic [W-1:0]      o_out_data
);
   // Depth must be a power of two: pointers wrap by overflow
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
   } ddcr_fifo_t;

   ddcr_fifo_t s;
   ddcr_fifo_t next_s;
   logic       push;
   logic       pop;

   // Handshake status from the fill count
   assign o_in_ready  = (s.cnt != (AW+1)'(D));
   assign o_out_valid = (s.cnt != '0);
   assign o_out_data  = s.mem[s.rp];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   // Pointer and count update
   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wp] = i_in_data;
         next_s.wp        = s.wp + 1'b1;
      end
      if (pop) begin
         next_s.rp = s.rp + 1'b1;
      end
      if (push && !pop) begin
         next_s.cnt = s.cnt + 1'b1;
      end else if (pop && !push) begin
         next_s.cnt = s.cnt - 1'b1;
      end
      if (i_rst) begin
         next_s = '0;
      end
   end

   // State register
   always_ff @(posedge i_clk) begin
      s <= next_s;
   end
endmodule

// Capture, phase search, retimer and registers
module ddcr_top (
   input  wire logic                 i_clk,
   input  wire logic                 i_rst,
   input  wire logic                 i_strap_mode,
   input  wire logic                 i_strap_serial_clock,
   input  wire logic                 i_sample_qualifier_clock,
   input  wire logic                 i_conversion_clock,
   input  wire logic [`DDCR_DW-1:0]  i_sample_bus,
   input  wire logic [4:0]           i_reg_addr,
   input  wire logic [7:0]           i_reg_wdata,
   input  wire logic                 i_reg_wr,
   output logic [7:0]                o_reg_rdata,
   output logic                      o_sample_qualifier_clock,
   output logic                      o_sample_qualifier_clock_oe,
   output logic [`DDCR_DW-1:0]       o_core_i,
   output logic [`DDCR_DW-1:0]       o_core_q,
   output logic                      o_core_stb,
   output logic                      o_searching,
   output logic                      o_internal_reference_disable
);
   localparam int DW = `DDCR_DW;

   typedef struct packed {
      logic [2:0]           qs;
      logic [2:0]           cs;
      logic [2:0]           ss;
      logic [2:0]           ms;
      logic                 ql;
      logic                 cl;
      logic                 sl;
      logic                 ml;
      logic [2:0][DW-1:0]   bs;
      logic [7:0]           r01;
      logic [7:0]           r02;
      logic [7:0]           r14;
      logic [DW-1:0]        hold;
      logic                 have;
      logic                 pend_v;
      logic [2*DW-1:0]      pend;
      ddcr_pkg::ddcr_srch_t st;
      logic                 searching;
      logic [7:0]           cnt;
      logic [7:0]           dcnt;
      logic [7:0]           tmo;
      logic                 dval;
      logic [1:0]           auto_i;
      logic [1:0]           auto_q;
      logic [1:0]           tick_i;
      logic [1:0]           tick_q;
      logic                 arm_i;
      logic                 arm_q;
      logic [DW-1:0]        stage_q;
      logic [DW-1:0]        core_i;
      logic [DW-1:0]        core_q;
      logic                 core_stb;
      logic                 qout;
      logic                 qoe;
      logic [7:0]           rdata;
   } ddcr_top_t;

   ddcr_top_t       s;
   ddcr_top_t       next_s;
   logic            fq;
   logic            fc;
   logic            fs;
   logic            fm;
   logic [7:0]      cfg;
   logic            ie;
   logic            cap_now;
   logic            cap_old;
   logic            rise;
   logic            fall;
   logic            i_edge;
   logic            q_edge;
   logic            first_e;
   logic            second_e;
   logic            conv_rise;
   logic            conv_fall;
   logic            reacq_rise;
   logic            restart;
   logic            fixed;
   logic            ovr_eff;
   logic [1:0]      code_i;
   logic [1:0]      code_q;
   logic            load_i;
   logic            f_ready;
   logic            f_valid;
   logic [2*DW-1:0] f_data;

   // A change counts once the second and third stages agree
   function automatic logic filt(input logic [2:0] sy, input logic lv);
      filt = (sy[1] == sy[2]) ? sy[2] : lv;
   endfunction

   // Offset binary for the core; the top bit flips in twos complement
   function automatic logic [DW-1:0] fmt(input logic [DW-1:0] d, input logic twos);
      fmt = twos ? {~d[DW-1], d[DW-2:0]} : d;
   endfunction

   // Filtered pin levels and the clock that captures data
   assign fq        = filt(s.qs, s.ql);
   assign fc        = filt(s.cs, s.cl);
   assign fs        = filt(s.ss, s.sl);
   assign fm        = filt(s.ms, s.ml);
   assign cfg       = s.ml ? `DDCR_RST_DATA : s.r02;
   assign ie        = cfg[`DDCR_BIT_IE];
   assign cap_now   = ie ? fq : fc;
   assign cap_old   = ie ? s.ql : s.cl;
   assign rise      = cap_now & ~cap_old;
   assign fall      = ~cap_now & cap_old;
   assign i_edge    = cfg[`DDCR_BIT_RISING] ? rise : fall;
   assign q_edge    = cfg[`DDCR_BIT_RISING] ? fall : rise;
   assign first_e   = cfg[`DDCR_BIT_FIRST] ? i_edge : q_edge;
   assign second_e  = cfg[`DDCR_BIT_FIRST] ? q_edge : i_edge;
   assign conv_rise = fc & ~s.cl;
   assign conv_fall = ~fc & s.cl;

   // Search triggers: reacquire write, serial clock rise in pin mode, fixed phase
   assign reacq_rise = i_reg_wr && (i_reg_addr == `DDCR_ADDR_PHASE)
                       && i_reg_wdata[`DDCR_BIT_REACQ] && !s.r14[`DDCR_BIT_REACQ];
   assign restart    = (!s.ml && reacq_rise) || (s.ml && fs && !s.sl);
   assign fixed      = s.ml && !fs;  // Filtered level, so a rise is not masked

   // Override takes the I field for both retimers; Q field is readback only
   assign ovr_eff = !s.ml && s.r14[`DDCR_BIT_OVR];
   assign code_i  = ovr_eff ? s.r14[`DDCR_BIT_IPH +: 2] : s.auto_i;
   assign code_q  = ovr_eff ? s.r14[`DDCR_BIT_IPH +: 2] : s.auto_q;
   assign load_i  = s.arm_i && (s.tick_i == 2'h1) && f_valid;

   ddcr_fifo #(
      .W (2*DW),
      .D (`DDCR_FIFO_DEPTH)
   ) u_fifo (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_in_valid  (s.pend_v),
      .o_in_ready  (f_ready),
      .i_in_data   (s.pend),
      .o_out_valid (f_valid),
      .i_out_ready (load_i),
      .o_out_data  (f_data)
   );

   // Whole next-state of the block
   always_comb begin
      next_s    = s;
      next_s.qs = {s.qs[1:0], i_sample_qualifier_clock};
      next_s.cs = {s.cs[1:0], i_conversion_clock};
      next_s.ss = {s.ss[1:0], i_strap_serial_clock};
      next_s.ms = {s.ms[1:0], i_strap_mode};
      next_s.bs = {s.bs[1:0], i_sample_bus};
      next_s.ql = fq;
      next_s.cl = fc;
      next_s.sl = fs;
      next_s.ml = fm;
      next_s.core_stb = 1'b0;

      // DDR pairing; a new pair overwrites a pending slot that the FIFO has not taken
      if (s.pend_v && f_ready) begin
         next_s.pend_v = 1'b0;
      end
      if (first_e) begin
         next_s.hold = s.bs[2];
         next_s.have = 1'b1;
      end else if (second_e && s.have) begin
         next_s.have   = 1'b0;
         next_s.pend_v = 1'b1;
         next_s.pend   = cfg[`DDCR_BIT_FIRST] ? {s.hold, s.bs[2]} : {s.bs[2], s.hold};
      end

      // Phase search: time from a conversion rise to the capture clock rise (the qualifier with bit 2 set)
      unique case (s.st)
         ddcr_pkg::DDCR_LOCKED: begin
         end
         ddcr_pkg::DDCR_WAIT: begin
            if (conv_rise) begin
               next_s.cnt  = 8'h00;
               next_s.dval = 1'b0;
               next_s.st   = ddcr_pkg::DDCR_MEASURE;
            end
         end
         ddcr_pkg::DDCR_MEASURE: begin
            if (s.cnt != 8'hFF) begin
               next_s.cnt = s.cnt + 8'h01;
            end
            if (rise && !s.dval) begin
               next_s.dval = 1'b1;
               next_s.dcnt = s.cnt;
            end
            if (conv_rise) begin
               next_s.cnt = 8'h00;
               if (s.dval) begin
                  next_s.auto_i    = ddcr_pkg::ddcr_quadrant(s.dcnt, s.cnt);
                  next_s.auto_q    = ddcr_pkg::ddcr_quadrant(s.dcnt, s.cnt);
                  next_s.searching = 1'b0;
                  next_s.st        = ddcr_pkg::DDCR_LOCKED;
               end
            end
         end
      endcase

      // Bound on the search; gives up on phase 2 rather than stay unusable
      if (s.searching && conv_rise) begin
         next_s.tmo = s.tmo + 8'h01;
         if (s.tmo == `DDCR_SEARCH_LAST) begin
            next_s.auto_i    = `DDCR_FIXED_CODE;
            next_s.auto_q    = `DDCR_FIXED_CODE;
            next_s.searching = 1'b0;
            next_s.st        = ddcr_pkg::DDCR_LOCKED;
         end
      end
      if (restart) begin
         next_s.st        = ddcr_pkg::DDCR_WAIT;
         next_s.searching = 1'b1;
         next_s.tmo       = 8'h00;
      end
      if (fixed) begin
         next_s.st        = ddcr_pkg::DDCR_LOCKED;
         next_s.searching = 1'b0;
         next_s.auto_i    = `DDCR_FIXED_CODE;
         next_s.auto_q    = `DDCR_FIXED_CODE;
      end

      // Retimer countdowns; phase only sampled at a conversion rise
      if (s.arm_i) begin
         if (s.tick_i == 2'h1) begin
            next_s.arm_i = 1'b0;
            if (f_valid) begin
               next_s.core_i   = fmt(f_data[2*DW-1:DW], cfg[`DDCR_BIT_TWOS]);
               next_s.stage_q  = f_data[DW-1:0];
               next_s.core_stb = 1'b1;
            end
         end else begin
            next_s.tick_i = s.tick_i - 2'h1;
         end
      end
      if (s.arm_q) begin
         if (s.tick_q == 2'h1) begin
            next_s.arm_q  = 1'b0;
            next_s.core_q = fmt(s.stage_q, cfg[`DDCR_BIT_TWOS]);
         end else begin
            next_s.tick_q = s.tick_q - 2'h1;
         end
      end
      if (conv_rise) begin
         next_s.tick_i = ddcr_pkg::ddcr_phase_of(code_i);
         next_s.tick_q = ddcr_pkg::ddcr_phase_of(code_q);
         next_s.arm_i  = 1'b1;
         next_s.arm_q  = 1'b1;
      end

      // Qualifier clock output; double rate marks both conversion edges
      next_s.qoe  = !s.ml && (cfg[`DDCR_BIT_SGL] || cfg[`DDCR_BIT_DBL]);
      next_s.qout = cfg[`DDCR_BIT_SGL] ? fc : (conv_rise || conv_fall);

      // Register writes; the searching bit is not writable
      if (i_reg_wr) begin
         case (i_reg_addr)
            `DDCR_ADDR_REF:   next_s.r01 = i_reg_wdata;
            `DDCR_ADDR_DATA:  next_s.r02 = i_reg_wdata;
            `DDCR_ADDR_PHASE: next_s.r14 = i_reg_wdata & `DDCR_PHASE_WMASK;
            default: begin
            end
         endcase
      end

      // Registered read data; unmapped offsets read zero
      case (i_reg_addr)
         `DDCR_ADDR_REF:   next_s.rdata = s.r01;
         `DDCR_ADDR_DATA:  next_s.rdata = s.r02;
         `DDCR_ADDR_PHASE: next_s.rdata = {code_q, 1'b0, s.searching,
                                           s.r14[`DDCR_BIT_REACQ], s.r14[`DDCR_BIT_OVR],
                                           code_i};
         default:          next_s.rdata = 8'h00;
      endcase

      // Reset starts a search, as the reset pulse does in register mode
      if (i_rst) begin
         next_s           = '0;
         next_s.r01       = `DDCR_RST_REF;
         next_s.r02       = `DDCR_RST_DATA;
         next_s.r14       = `DDCR_RST_PHASE;
         next_s.st        = ddcr_pkg::DDCR_WAIT;
         next_s.searching = 1'b1;
      end
   end

   // State register
   always_ff @(posedge i_clk) begin
      s <= next_s;
   end

   // Outputs straight from the state register
   assign o_reg_rdata                  = s.rdata;
   assign o_sample_qualifier_clock     = s.qout;
   assign o_sample_qualifier_clock_oe  = s.qoe;
   assign o_core_i                     = s.core_i;
   assign o_core_q                     = s.core_q;
   assign o_core_stb                   = s.core_stb;
   assign o_searching                  = s.searching;
   assign o_internal_reference_disable = s.r01[`DDCR_BIT_REF_DIS];

   default clocking ddcr_cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   AST_LOCK_BOUND: assert property (
      (s.searching && conv_rise && s.tmo == 8'h7F && !restart && !fixed) |=> !s.searching)
      else $error("search not ended at its bound");
   AST_REACQ_SEARCH: assert property (
      (reacq_rise && !s.ml) |=> (s.searching && s.st == ddcr_pkg::DDCR_WAIT))
      else $error("reacquire did not restart search");
   AST_FORCE_BOTH: assert property (
      (ovr_eff && conv_rise) |=> (s.tick_i == s.tick_q
         && s.tick_i == ddcr_pkg::ddcr_phase_of($past(s.r14[1:0]))))
      else $error("override did not force both retimers");
   AST_PIN_FIXED: assert property (
      fixed |=> (!s.searching && s.auto_i == 2'h0 && s.auto_q == 2'h0))
      else $error("pin mode fixed phase not applied");
   AST_TICK_STEP: assert property (
      (s.arm_i && !conv_rise && s.tick_i == 2'h3) |=> (s.tick_i == 2'h2 ##1 s.tick_i == 2'h1))
      else $error("retimer countdown disturbed");
   AST_CORE_FMT: assert property (
      load_i |=> (s.core_stb && s.core_i[DW-1] == ($past(f_data[2*DW-1]) ^ $past(cfg[7]))))
      else $error("core word format wrong");
   AST_CLK_OUT: assert property (
      (!s.ml && (cfg[1] || cfg[0])) |=> o_sample_qualifier_clock_oe)
      else $error("qualifier clock output not enabled");
   AST_PAIR_PUSH: assert property (
      (second_e && s.have && !first_e) |=> (s.pend_v && s.pend[DW-1:0] ==
         ($past(cfg[5]) ? $past(s.bs[2]) : $past(s.hold))))
      else $error("pair not formed in channel order");
   AST_PHASE2_LAT: assert property (
      (conv_rise && ddcr_pkg::ddcr_phase_of(code_i) == 2'h2 && f_valid)
         ##1 (!conv_rise) [*2] |=> s.core_stb)
      else $error("phase 2 load not on third cycle");
   AST_SEARCH_READ: assert property (
      (i_reg_addr == `DDCR_ADDR_PHASE) |=> (o_reg_rdata[4] == $past(s.searching)))
      else $error("searching readback wrong");

   COV_LOCK:  cover property (s.searching ##1 !s.searching);
   COV_LOAD:  cover property (s.core_stb);
   COV_FORCE: cover property (ovr_eff && conv_rise);
   COV_FULL:  cover property (s.pend_v && !f_ready);
endmodule

/* tb_top.sv */
// Self-checking bench of the capture retimer against the FPGA-side model
`timescale 1ns/1ps
module tb_top;
   logic        clk;
   logic        rst;
   logic        strap;
   logic        sclk;
   logic        conv = 1'b0;
   logic        hold;
   logic        qclk;
   logic [13:0] bus;
   logic [4:0]  addr;
   logic [7:0]  wdata;
   logic        wr;
   logic [7:0]  rdata;
   logic        qco;
   logic        oe;
   logic [13:0] ci;
   logic [13:0] cq;
   logic        stb;
   logic        srch;
   logic        refdis;
   int          mismatches;
   int          checked;
   int          cyc = 0;
   int          pos0;
   int          chg;
   int          hi;

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Conversion clock at one eighth of the bench clock
   always @(negedge clk) begin
      cyc <= cyc + 1;
      if (cyc % 4 == 3) conv <= ~conv;
   end

   ddcr_fpga_model u_ddcr_fpga_model (.i_clk(clk), .i_conv(conv), .i_hold(hold),
      .o_qclk(qclk), .o_bus(bus));

   ddcr_top u_ddcr_top (.i_clk(clk), .i_rst(rst), .i_strap_mode(strap),
      .i_strap_serial_clock(sclk), .i_sample_qualifier_clock(qclk),
      .i_conversion_clock(conv), .i_sample_bus(bus), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .i_reg_wr(wr), .o_reg_rdata(rdata),
      .o_sample_qualifier_clock(qco), .o_sample_qualifier_clock_oe(oe),
      .o_core_i(ci), .o_core_q(cq), .o_core_stb(stb), .o_searching(srch),
      .o_internal_reference_disable(refdis));

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic end_sim();
      $display("Comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Write strobe held one full cycle around a single rising edge
   task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask

   task automatic rd_reg(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
      @(negedge clk);
      addr = a;
      @(posedge clk);
      #1 chk("reg_rdata", {8'h00, e}, {8'h00, rdata & m});
   endtask

   // Bounded waits; running out ends the run as a mismatch
   task automatic wait_srch(input logic lvl, input int lim);
      for (int n = 0; n < lim && srch !== lvl; n++) @(posedge clk) #1;
      chk("searching", {15'h0000, lvl}, {15'h0000, srch});
      if (srch !== lvl) end_sim();
   endtask

   // Steps past any standing pulse first; returns while the strobe stands
   task automatic wait_stb();
      @(posedge clk) #1;
      for (int n = 0; n < 40 && stb !== 1'b1; n++) @(posedge clk) #1;
      chk("core_stb", 16'h0001, {15'h0000, stb});
      if (stb !== 1'b1) end_sim();
   endtask

   task automatic watch();
      logic p;
      chg = 0;
      hi = 0;
      p = qco;
      repeat (32) begin
         @(posedge clk) #1;
         chg += (qco !== p);
         hi += (qco === 1'b1);
         p = qco;
      end
   endtask

   // All four latch orders with both formats; Q word lags one period when bits 5 and 4 match, two with bit 4 alone, none with bit 5 alone
   task automatic t_stream();
      logic t;
      logic f;
      logic r;
      logic [12:0] d;
      for (int k = 0; k < 8; k++) begin
         {t, f, r} = 3'(k);
         wr_reg(5'h02, {t, 1'b0, f, r, 4'h4});
         repeat (8) wait_stb();
         d = (f == r) ? 13'h0001 : (r ? 13'h0002 : 13'h0000);
         chk("core_i_tag", {15'h0000, ~r ^ t}, {15'h0000, ci[13]});
         chk("core_q_tag", {15'h0000, r ^ t}, {15'h0000, cq[13]});
         chk("core_q_seq", {3'h0, ci[12:0] - d}, {3'h0, cq[12:0]});
      end
      wr_reg(5'h02, 8'h04);
   endtask

   // Forced phase moves the core strobe one cycle per step of phase number away from that of code 00
   task automatic t_phase();
      int dl[4] = '{0, 1, 1, 7};
      for (int c = 0; c < 4; c++) begin
         wr_reg(5'h14, {2'(c), 4'h1, 2'(c)}); // Same code in both fields
         rd_reg(5'h14, 8'hCF, {2'(c), 4'h1, 2'(c)});
         repeat (5) wait_stb();
         if (c == 0) pos0 = cyc;
         else chk("stb_offset", 16'(dl[c]), 16'(((cyc - pos0) % 8 + 8) % 8));
      end
      wr_reg(5'h14, 8'h00);
   endtask

   // Clock output options, with capture running from the conversion clock
   task automatic t_clkout();
      hold = 1'b1;
      wr_reg(5'h02, 8'h02);
      repeat (8) @(posedge clk);
      #1 chk("clk_out_oe", 16'h0001, {15'h0000, oe});
      watch();
      chk("clk_out_changes", 16'h0008, 16'(chg));
      repeat (3) wait_stb();
      wr_reg(5'h02, 8'h01);
      repeat (8) @(posedge clk);
      watch();
      chk("clk_out_pulses", 16'h0008, 16'(hi));
      wr_reg(5'h02, 8'h04);
      hold = 1'b0;
      repeat (8) @(posedge clk);
      #1 chk("clk_out_oe", 16'h0000, {15'h0000, oe});
   endtask

   initial begin
      {rst, strap, sclk, hold, wr} = 5'h10;
      {addr, wdata, mismatches, checked} = '0;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      chk("searching", 16'h0001, {15'h0000, srch});
      rd_reg(5'h01, 8'hFF, 8'h00);
      rd_reg(5'h02, 8'hFF, 8'h04);
      rd_reg(5'h03, 8'hFF, 8'h00);
      rd_reg(5'h14, 8'h3C, 8'h10);
      wait_srch(1'b0, 1064);
      rd_reg(5'h14, 8'h3C, 8'h00);
      wr_reg(5'h01, 8'h01);
      chk("ref_disable", 16'h0001, {15'h0000, refdis});
      wr_reg(5'h01, 8'h00);
      chk("ref_disable", 16'h0000, {15'h0000, refdis});
      t_stream();
      t_phase();
      wr_reg(5'h14, 8'h08);
      wait_srch(1'b1, 3);
      wait_srch(1'b0, 1064);
      wr_reg(5'h14, 8'h00);
      t_clkout();
      @(negedge clk);
      strap = 1'b1;
      repeat (8) @(negedge clk);
      wait_srch(1'b0, 12);
      rd_reg(5'h14, 8'hC3, 8'h00);
      @(negedge clk);
      sclk = 1'b1;
      wait_srch(1'b1, 12);
      wait_srch(1'b0, 1064);
      @(negedge clk);
      strap = 1'b0;
      wait_srch(1'b0, 1064);
      // Parked qualifier: search runs to its bound, then falls back to code 00
      repeat (8) @(negedge clk);
      hold = 1'b1;
      wr_reg(5'h14, 8'h08);
      wait_srch(1'b1, 3);
      repeat (1000) @(posedge clk);
      #1 chk("searching", 16'h0001, {15'h0000, srch});
      wait_srch(1'b0, 100);
      rd_reg(5'h14, 8'hC3, 8'h00);
      end_sim();
   end
endmodule
